// *** inc/dms_pkg.sv ***
// Shared constants for the direct-mode serial link between modem and host
package dms_pkg;
	// Clock period and documented times, each in its own unit
	localparam int unsigned CLK_PERIOD_PS  = 4000;
	localparam int unsigned SMP_PERIOD_PS  = 19250000;
	localparam int unsigned TXCLK_HI_PS    = 1750000;
	localparam int unsigned RXCLK_HI_PS    = 875000;
	localparam int unsigned LATENCY_US     = 500;
	localparam int unsigned DLY_LONG_US    = 13500;
	localparam int unsigned DLY_SHORT_US   = 3500;
	// Derived cycle counts
	localparam int unsigned SMP_CYC        = SMP_PERIOD_PS / CLK_PERIOD_PS;
	localparam int unsigned TXCLK_HI_CYC   = TXCLK_HI_PS / CLK_PERIOD_PS;
	localparam int unsigned RXCLK_HI_CYC   = RXCLK_HI_PS / CLK_PERIOD_PS;
	// Scaled in two steps so the product stays inside 32 bits
	localparam int unsigned DLY_LONG_CYC   = (DLY_LONG_US * 1000) / (CLK_PERIOD_PS / 1000);
	localparam int unsigned DLY_SHORT_CYC  = (DLY_SHORT_US * 1000) / (CLK_PERIOD_PS / 1000);
	localparam int unsigned LAT_SMP        = (LATENCY_US * 1000000) / SMP_PERIOD_PS;
	localparam int unsigned CNT_W          = 22;
	// Modem register fields
	localparam logic [7:0]  OPM_DIRECT     = 8'h01;
	localparam int unsigned SPM_DLY_BIT    = 5;
	localparam int unsigned SPM_DCD_BIT    = 4;
	localparam int unsigned LPC_DOZE_BIT   = 7;
	localparam int unsigned LPC_CTRLF_BIT  = 6;
	// Host controller APB map
	localparam logic [7:0]  HOST_CTRL_OFS  = 8'h00;
	localparam logic [7:0]  HOST_STAT_OFS  = 8'h04;
	localparam int unsigned CTRL_TXREQ_BIT = 0;
	localparam int unsigned CTRL_CMD_BIT   = 1;
	localparam int unsigned CTRL_TXD_BIT   = 2;
	localparam int unsigned CTRL_SYNC_BIT  = 3;
	localparam logic [3:0]  CTRL_RESET     = 4'h0;
endpackage : dms_pkg

// *** inc/dms_if.sv ***
// Serial connector between host terminal and modem
`timescale 1ns/1ps
interface dms_if;
	logic txd;
	logic rts_n;
	logic dtr_n;
	logic rxd;
	logic cts_n;
	logic dcd_n;
	logic dsr_n;
	modport dev  (input txd, input rts_n, input dtr_n,
		output rxd, output cts_n, output dcd_n, output dsr_n);
	modport host (output txd, output rts_n, output dtr_n,
		input rxd, input cts_n, input dcd_n, input dsr_n);
endinterface : dms_if

// *** verilog/dms_modem_end.sv ***
// Modem end of the direct-mode serial link
// Operation
// RULE1 - Sample transmit pin at fixed 51.9 kHz
// RULE2 - Replay received levels on receive pin
// RULE3 - Host holds transmit levels several samples
// RULE4 - RTS low transmits; falling edge starts
// RULE5 - Host keeps RTS high, lowers after DSR
// RULE6 - About 500 us end-to-end latency
// RULE7 - Operation-mode code 01h selects direct mode
// RULE8 - Delay bit selects 13.5 or 3.5 ms
// RULE9 - Both modems share delay setting
// RULE10 - DCD bit selects carrier or clock
// RULE11 - CTS low after start delay
// RULE12 - Legacy DCD low while receiving data
// RULE13 - Receive pin high when no data
// RULE14 - DTR high selects command-accept mode
// RULE15 - Send ID when vacant, then DSR low
// RULE16 - Serial setting affects command mode only
// RULE17 - Transmit clock starts with CTS low
// RULE18 - Sample 1.75 us before clock rise
// RULE19 - Receive clock high 875 ns, data rises
// RULE20 - Doze only when low-power bit 7 set
// RULE21 - DTR rise dozes, fall wakes, DSR reports
// RULE22 - In doze accept only wakeup packet
// RULE23 - Free-running divider makes sample strobe
// RULE24 - No address or error checks, broadcast
`timescale 1ns/1ps
module dms_modem_end
	import dms_pkg::*;
#(
	parameter int unsigned SMP_CYC_P   = SMP_CYC,
	parameter int unsigned DLY_LONG_P  = DLY_LONG_CYC,
	parameter int unsigned DLY_SHORT_P = DLY_SHORT_CYC,
	parameter int unsigned LAT_SMP_P   = LAT_SMP
) (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	input  wire logic [7:0] operation_mode_select,
	input  wire logic [7:0] serial_interface_setting,
	input  wire logic [7:0] special_mode_settings,
	input  wire logic [7:0] low_power_configuration,
	input  wire logic       chan_busy,
	input  wire logic       rx_valid,
	input  wire logic       rx_smp_stb,
	input  wire logic       rx_smp_bit,
	input  wire logic       wake_pkt,
	output logic            radio_tx_en,
	output logic            radio_tx_stb,
	output logic            radio_tx_bit,
	output logic            id_send,
	output logic            cmd_mode,
	output logic [7:0]      cmd_ser_cfg,
	output logic            doze,
	output logic            ctrl_freq,
	dms_if.dev              lnk
);
	typedef enum logic [2:0] {DS_INIT, DS_RX, DS_TXWAIT, DS_TX, DS_DOZE} dms_state_t;

	dms_state_t           st_r, st_nxt;
	logic [2:0]           s1_r, s2_r, s3_r;
	logic [CNT_W-1:0]     smp_cnt_r, smp_cnt_nxt;
	logic [CNT_W-1:0]     dly_cnt_r, dly_cnt_nxt;
	logic [CNT_W-1:0]     rxhi_cnt_r, rxhi_cnt_nxt;
	logic [LAT_SMP_P-1:0] line_r, line_nxt;
	logic                 rxd_r, rxd_nxt;
	logic                 cts_n_r, cts_n_nxt;
	logic                 dcd_n_r, dcd_n_nxt;
	logic                 dsr_n_r, dsr_n_nxt;
	logic                 tx_stb_r, tx_stb_nxt;
	logic                 id_r, id_nxt;
	logic                 cmd_r, cmd_nxt;
	logic [7:0]           ser_r, ser_nxt;

	logic txd_s, rts_s, dtr_s, rts_fall, dtr_rise;
	logic direct, clk_mode, smp_stb;

	// Pins from the host cross into pclk; only s2/s3 feed logic
	assign txd_s    = s2_r[0];
	assign rts_s    = s2_r[1];
	assign dtr_s    = s2_r[2];
	assign rts_fall = s3_r[1] & ~s2_r[1];
	assign dtr_rise = ~s3_r[2] & s2_r[2];
	assign direct   = (operation_mode_select == OPM_DIRECT); // see RULE7
	assign clk_mode = special_mode_settings[SPM_DCD_BIT]; // see RULE10
	assign smp_stb  = (smp_cnt_r == '0); // see RULE23

	always_comb begin
		st_nxt       = st_r;
		smp_cnt_nxt  = smp_cnt_r;
		dly_cnt_nxt  = dly_cnt_r;
		rxhi_cnt_nxt = rxhi_cnt_r;
		line_nxt     = line_r;
		rxd_nxt      = rxd_r;
		cts_n_nxt    = cts_n_r;
		dcd_n_nxt    = dcd_n_r;
		dsr_n_nxt    = dsr_n_r;
		tx_stb_nxt   = 1'b0;
		id_nxt       = 1'b0;
		cmd_nxt      = dtr_s; // see RULE14
		// Baud setting only matters to the command channel
		ser_nxt      = dtr_s ? serial_interface_setting : ser_r; // see RULE16

		// Fixed-rate divider, never realigned to data edges
		if (smp_cnt_r == CNT_W'(SMP_CYC_P - 1)) begin
			smp_cnt_nxt = '0; // see RULE23
		end else begin
			smp_cnt_nxt = smp_cnt_r + 1'b1;
		end

		unique case (st_r)
			DS_INIT: begin
				dsr_n_nxt = 1'b1;
				if (!chan_busy) begin
					id_nxt    = 1'b1; // see RULE15
					dsr_n_nxt = 1'b0; // see RULE15
					st_nxt    = DS_RX;
				end
			end
			DS_RX: begin
				cts_n_nxt = 1'b1;
				if (dtr_rise && low_power_configuration[LPC_DOZE_BIT]) begin
					st_nxt    = DS_DOZE; // see RULE20
					dsr_n_nxt = 1'b1; // see RULE21
					rxd_nxt   = 1'b1;
					dcd_n_nxt = 1'b1;
				end else if (rts_fall && direct && !dtr_s) begin
					st_nxt      = DS_TXWAIT; // see RULE4
					dly_cnt_nxt = special_mode_settings[SPM_DLY_BIT] ?
						CNT_W'(DLY_SHORT_P) : CNT_W'(DLY_LONG_P); // see RULE8
					rxd_nxt     = 1'b1;
					dcd_n_nxt   = 1'b1;
				end else if (!direct) begin
					rxd_nxt   = 1'b1;
					dcd_n_nxt = 1'b1;
				end else if (clk_mode) begin
					// Receive clock: data and clock rise together
					if (rx_valid && rx_smp_stb) begin
						rxd_nxt      = rx_smp_bit; // see RULE2
						dcd_n_nxt    = 1'b1; // see RULE19
						rxhi_cnt_nxt = CNT_W'(RXCLK_HI_CYC);
					end else if (rxhi_cnt_r > CNT_W'(1)) begin
						rxhi_cnt_nxt = rxhi_cnt_r - 1'b1;
					end else begin
						rxhi_cnt_nxt = '0;
						dcd_n_nxt    = 1'b0; // see RULE19
					end
					if (!rx_valid) begin
						rxd_nxt = 1'b1; // see RULE13
					end
				end else begin
					// No address or error filter: any carrier is replayed
					dcd_n_nxt = ~rx_valid; // see RULE12
					if (!rx_valid) begin
						rxd_nxt = 1'b1; // see RULE13
					end else if (rx_smp_stb) begin
						rxd_nxt = rx_smp_bit; // see RULE2
					end
				end
			end
			DS_TXWAIT: begin
				if (rts_s) begin
					st_nxt = DS_RX;
				end else if (dly_cnt_r <= CNT_W'(1)) begin
					st_nxt    = DS_TX;
					cts_n_nxt = 1'b0; // see RULE11
					line_nxt  = '1;
				end else begin
					dly_cnt_nxt = dly_cnt_r - 1'b1;
				end
			end
			DS_TX: begin
				if (rts_s) begin
					st_nxt    = DS_RX; // see RULE4
					cts_n_nxt = 1'b1;
					dcd_n_nxt = 1'b1;
				end else begin
					if (smp_stb) begin
						// Delay line sets the end-to-end latency
						line_nxt   = {line_r[LAT_SMP_P-2:0], txd_s}; // see RULE1 RULE6
						tx_stb_nxt = 1'b1; // see RULE24
					end
					// Clock rises 1.75 us after the sample, high 1.75 us
					if (clk_mode) begin
						dcd_n_nxt = (smp_cnt_nxt >= CNT_W'(TXCLK_HI_CYC)) &&
							(smp_cnt_nxt < CNT_W'(2 * TXCLK_HI_CYC)); // see RULE17 RULE18
					end else begin
						dcd_n_nxt = 1'b1;
					end
				end
			end
			DS_DOZE: begin
				// Normal traffic is dropped here; only wakeup counts
				if (!dtr_s || wake_pkt) begin
					st_nxt    = DS_RX; // see RULE21 RULE22
					dsr_n_nxt = 1'b0; // see RULE21
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r       <= DS_INIT;
			s1_r       <= 3'h3;
			s2_r       <= 3'h3;
			s3_r       <= 3'h3;
			smp_cnt_r  <= '0;
			dly_cnt_r  <= '0;
			rxhi_cnt_r <= '0;
			line_r     <= '1;
			rxd_r      <= 1'b1;
			cts_n_r    <= 1'b1;
			dcd_n_r    <= 1'b1;
			dsr_n_r    <= 1'b1;
			tx_stb_r   <= 1'b0;
			id_r       <= 1'b0;
			cmd_r      <= 1'b0;
			ser_r      <= 8'h00;
		end else if (ce) begin
			s1_r       <= {lnk.dtr_n, lnk.rts_n, lnk.txd};
			s2_r       <= s1_r;
			s3_r       <= s2_r;
			st_r       <= st_nxt;
			smp_cnt_r  <= smp_cnt_nxt;
			dly_cnt_r  <= dly_cnt_nxt;
			rxhi_cnt_r <= rxhi_cnt_nxt;
			line_r     <= line_nxt;
			rxd_r      <= rxd_nxt;
			cts_n_r    <= cts_n_nxt;
			dcd_n_r    <= dcd_n_nxt;
			dsr_n_r    <= dsr_n_nxt;
			tx_stb_r   <= tx_stb_nxt;
			id_r       <= id_nxt;
			cmd_r      <= cmd_nxt;
			ser_r      <= ser_nxt;
		end
	end

	logic doze_r, tx_en_r, ctrlf_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			doze_r  <= 1'b0;
			tx_en_r <= 1'b0;
			ctrlf_r <= 1'b0;
		end else if (ce) begin
			doze_r  <= (st_nxt == DS_DOZE);
			tx_en_r <= (st_nxt == DS_TX);
			ctrlf_r <= low_power_configuration[LPC_CTRLF_BIT]; // see RULE20
		end
	end

	assign lnk.rxd      = rxd_r;
	assign lnk.cts_n    = cts_n_r;
	assign lnk.dcd_n    = dcd_n_r;
	assign lnk.dsr_n    = dsr_n_r;
	assign radio_tx_en  = tx_en_r;
	assign radio_tx_stb = tx_stb_r;
	assign radio_tx_bit = line_r[LAT_SMP_P-1];
	assign id_send      = id_r;
	assign cmd_mode     = cmd_r;
	assign cmd_ser_cfg  = ser_r;
	assign doze         = doze_r;
	assign ctrl_freq    = ctrlf_r;
endmodule : dms_modem_end

// *** verilog/dms_host_end.sv ***
// Host terminal end of the direct-mode link, controlled over APB
`timescale 1ns/1ps
module dms_host_end
	import dms_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	dms_if.host              lnk
);
	logic [3:0]  ctrl_r, ctrl_nxt;
	logic [3:0]  s1_r, s2_r;
	logic        dcd_d_r;
	logic        rts_n_r, rts_n_nxt;
	logic        txd_r, txd_nxt;
	logic        pready_r, pready_nxt;
	logic        err_r, err_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic        wr_go, hit;

	assign wr_go = psel & penable & pready_r & pwrite;
	assign hit   = (paddr == HOST_CTRL_OFS) || (paddr == HOST_STAT_OFS);

	always_comb begin
		ctrl_nxt   = ctrl_r;
		rts_n_nxt  = rts_n_r;
		txd_nxt    = txd_r;
		pready_nxt = psel & ~penable;
		// Error flag stands only in the access cycle, beside pready
		err_nxt    = psel & ~penable & ~hit;
		rd_nxt     = rd_r;
		if (psel && !penable) begin
			unique case (paddr)
				HOST_CTRL_OFS: rd_nxt = {28'h0000000, ctrl_r};
				HOST_STAT_OFS: rd_nxt = {27'h0000000, ~rts_n_r, s2_r};
				default:       rd_nxt = 32'h00000000;
			endcase
		end
		if (wr_go && paddr == HOST_CTRL_OFS) begin
			ctrl_nxt = pwdata[3:0];
		end
		// Raise RTS whenever not requested; lower only after DSR seen low
		if (!ctrl_r[CTRL_TXREQ_BIT]) begin
			rts_n_nxt = 1'b1; // see RULE5
		end else if (!s2_r[2]) begin
			rts_n_nxt = 1'b0; // see RULE4 RULE5
		end
		// Sync mode moves data only on a clock rise, giving a full period
		if (!ctrl_r[CTRL_SYNC_BIT] || (s2_r[1] && !dcd_d_r)) begin
			txd_nxt = ctrl_r[CTRL_TXD_BIT]; // see RULE3 RULE18
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= CTRL_RESET;
			s1_r     <= 4'hf;
			s2_r     <= 4'hf;
			dcd_d_r  <= 1'b1;
			rts_n_r  <= 1'b1;
			txd_r    <= 1'b1;
			pready_r <= 1'b0;
			err_r    <= 1'b0;
			rd_r     <= 32'h00000000;
		end else if (ce) begin
			// Status bits {rxd, dsr, dcd, cts}
			s1_r     <= {lnk.rxd, lnk.dsr_n, lnk.dcd_n, lnk.cts_n};
			s2_r     <= s1_r;
			dcd_d_r  <= s2_r[1];
			ctrl_r   <= ctrl_nxt;
			rts_n_r  <= rts_n_nxt;
			txd_r    <= txd_nxt;
			pready_r <= pready_nxt;
			err_r    <= err_nxt;
			rd_r     <= rd_nxt;
		end
	end

	assign lnk.rts_n = rts_n_r;
	assign lnk.dtr_n = ctrl_r[CTRL_CMD_BIT]; // see RULE14
	assign lnk.txd   = txd_r;
	assign prdata    = rd_r;
	assign pready    = pready_r;
	assign pslverr   = err_r;
endmodule : dms_host_end

// *** verification/dms_link_props.sv ***
// Timing checks on the serial connector between the two ends
`timescale 1ns/1ps
module dms_link_props
	import dms_pkg::*;
#(
	parameter int unsigned DLY_LONG_P  = DLY_LONG_CYC,
	parameter int unsigned DLY_SHORT_P = DLY_SHORT_CYC
) (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       txd,
	input wire logic       rts_n,
	input wire logic       dtr_n,
	input wire logic       rxd,
	input wire logic       cts_n,
	input wire logic       dcd_n,
	input wire logic       dsr_n,
	input wire logic [7:0] operation_mode_select,
	input wire logic [7:0] special_mode_settings,
	input wire logic [7:0] low_power_configuration
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [31:0] low_r;
	logic [31:0] low_nxt;
	logic [31:0] dly;
	logic        lp;
	assign dly = special_mode_settings[SPM_DLY_BIT] ? DLY_SHORT_P : DLY_LONG_P;
	assign lp  = low_power_configuration[LPC_DOZE_BIT];
	always_comb begin
		low_nxt = rts_n ? 32'h0 : low_r + 32'h1;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_r <= 32'h0;
		end else begin
			low_r <= low_nxt;
		end
	end
	a_cts_needs_rts: assert property ($fell(cts_n) |-> !rts_n) else $error("cts without rts");
	a_cts_release: assert property ($rose(rts_n) |-> ##[1:6] cts_n) else $error("cts held");
	a_cts_early: assert property ($fell(cts_n) |-> low_r >= dly) else $error("cts early");
	a_cts_late: assert property (low_r == dly + 12 && !dtr_n && !dsr_n
		&& operation_mode_select == OPM_DIRECT |-> !cts_n) else $error("cts late");
	a_rxd_idle_high: assert property (!special_mode_settings[SPM_DCD_BIT] && dcd_n
		&& $past(dcd_n) |-> rxd) else $error("rxd low without carrier");
	a_doze_enter: assert property ($rose(dtr_n) && !dsr_n && lp && cts_n
		|-> ##[1:8] dsr_n) else $error("no doze");
	a_doze_disabled: assert property ($rose(dtr_n) && !dsr_n && !lp
		|-> !dsr_n [*8]) else $error("doze while disabled");
	a_doze_leave: assert property ($fell(dtr_n) && dsr_n |-> ##[1:8] !dsr_n)
		else $error("no wake");
	c_tx_start: cover property ($fell(cts_n));
	c_doze: cover property ($rose(dsr_n));
	c_carrier: cover property ($fell(dcd_n));
endmodule : dms_link_props

// *** verification/test_direct_mode_serial_port.sv ***
// Bench for host and modem ends joined over the serial connector
`timescale 1ns/1ps
module test_direct_mode_serial_port;
	import dms_pkg::*;
	localparam int unsigned SMP = 1000;
	localparam int unsigned DL  = 60;
	localparam int unsigned DS  = 30;
	localparam int unsigned LAT = 2;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0]  opm = 8'h01;
	logic [7:0]  sis = 8'h00;
	logic [7:0]  spm = 8'h00;
	logic [7:0]  lpc = 8'h00;
	logic        busy = 1'b1;
	logic        rxv = 1'b0;
	logic        wake = 1'b0;
	logic        rx_stb = 1'b0;
	logic        rx_bit = 1'b1;
	logic        dcd_q = 1'b1;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [7:0]  ser;
	logic        pready, pslverr, err, tx_en, stb, tbit, ids, cmd, doze, cfq;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          stb_cnt = 0;
	int          id_cnt = 0;
	int          rise_cnt = 0;
	int          n, n0;
	dms_if lnk_if ();
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		stb_cnt <= stb_cnt + stb;
		id_cnt <= id_cnt + ids;
		dcd_q <= lnk_if.dcd_n;
		rise_cnt <= rise_cnt + (lnk_if.dcd_n & ~dcd_q);
	end
	dms_host_end dms_host_end_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lnk(lnk_if.host));
	// Radio receive side comes from the bench; a sending modem never hears itself
	dms_modem_end #(.SMP_CYC_P(SMP), .DLY_LONG_P(DL), .DLY_SHORT_P(DS), .LAT_SMP_P(LAT))
		dms_modem_end_i (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.operation_mode_select(opm), .serial_interface_setting(sis),
		.special_mode_settings(spm), .low_power_configuration(lpc), .chan_busy(busy),
		.rx_valid(rxv), .rx_smp_stb(rx_stb), .rx_smp_bit(rx_bit), .wake_pkt(wake),
		.radio_tx_en(tx_en), .radio_tx_stb(stb), .radio_tx_bit(tbit), .id_send(ids),
		.cmd_mode(cmd), .cmd_ser_cfg(ser), .doze(doze), .ctrl_freq(cfq), .lnk(lnk_if.dev));
	dms_link_props #(.DLY_LONG_P(DL), .DLY_SHORT_P(DS)) dms_link_props_i (.pclk(pclk),
		.presetn(presetn), .txd(lnk_if.txd), .rts_n(lnk_if.rts_n), .dtr_n(lnk_if.dtr_n),
		.rxd(lnk_if.rxd), .cts_n(lnk_if.cts_n), .dcd_n(lnk_if.dcd_n), .dsr_n(lnk_if.dsr_n),
		.operation_mode_select(opm), .special_mode_settings(spm),
		.low_power_configuration(lpc));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Request held until pready is seen high at a rising edge; only the watchdog ends a wait
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rx_pulse(input logic b);
		@(posedge pclk);
		rx_stb <= 1'b1;
		rx_bit <= b;
		@(posedge pclk);
		rx_stb <= 1'b0;
	endtask : rx_pulse
	task automatic wait_pin(input int s, input logic lvl);
		n = 0;
		while (((s == 0) ? lnk_if.cts_n : lnk_if.dsr_n) !== lvl && n < 400) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 400) begin
			n_mismatch++;
			$display("MISMATCH pin wait expected %h seen %h", lvl, ~lvl);
		end
	endtask : wait_pin
	task automatic end_sim();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		#200000;
		n_mismatch++;
		end_sim();
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, HOST_STAT_OFS, 32'h0);
		chk("status busy", 32'hf, rd);
		apb(1'b0, 8'h08, 32'h0);
		chk("unmapped", 32'h1, rd | {31'h0, err});
		busy <= 1'b0;
		wait_pin(1, 1'b0);
		repeat (3) @(negedge pclk);
		chk("id pulses", 32'h1, id_cnt);
		for (int i = 0; i < 2; i++) begin
			spm <= 8'(i << SPM_DLY_BIT);
			sis <= i ? 8'hff : 8'h00;
			rxv <= 1'b1;
			apb(1'b1, HOST_CTRL_OFS, 32'h5);
			wait_pin(0, 1'b0);
			chk("cts delay", 32'h1, 32'(n >= (i ? DS : DL) && n <= (i ? DS : DL) + 16));
			chk("tx state", 32'h3, {30'h0, tx_en, lnk_if.dcd_n});
			n0 = stb_cnt;
			repeat (4 * SMP) @(negedge pclk);
			chk("samples", 32'd4, 32'(stb_cnt - n0));
			chk("ser held", 32'h0, {24'h0, ser});
			apb(1'b0, HOST_CTRL_OFS, 32'h0);
			chk("ctrl readback", 32'h5, rd);
			apb(1'b0, HOST_STAT_OFS, 32'h0);
			chk("status tx", 32'h1a, rd);
			apb(1'b1, HOST_CTRL_OFS, 32'h1);
			repeat (SMP) @(negedge pclk);
			chk("tx bit early", 32'h1, 32'(tbit));
			repeat ((LAT + 1) * SMP) @(negedge pclk);
			chk("tx bit delayed", 32'h0, 32'(tbit));
			apb(1'b1, HOST_CTRL_OFS, 32'h0);
			wait_pin(0, 1'b1);
			rx_pulse(1'b0);
			repeat (2) @(negedge pclk);
			chk("rxd replay", 32'h0, {30'h0, lnk_if.dcd_n, lnk_if.rxd});
			rxv <= 1'b0;
			repeat (4) @(negedge pclk);
			chk("idle", 32'h3, {30'h0, lnk_if.dcd_n, lnk_if.rxd});
		end
		for (int i = 0; i < 2; i++) begin
			opm <= i ? 8'h00 : OPM_DIRECT;
			apb(1'b1, HOST_CTRL_OFS, i ? 32'h1 : 32'h3);
			repeat (DL + 40) @(negedge pclk);
			chk("refused", {31'h0, ~i[0]} | 32'h2, {30'h0, lnk_if.cts_n, cmd});
			chk("cmd setting", 32'hff, {24'h0, ser});
			apb(1'b1, HOST_CTRL_OFS, 32'h0);
		end
		opm <= OPM_DIRECT;
		lpc <= 8'hc0;
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, HOST_CTRL_OFS, 32'h2);
			wait_pin(1, 1'b1);
			chk("doze", 32'h3, {30'h0, doze, cfq});
			@(posedge pclk);
			if (i == 0) begin
				wake <= 1'b1;
				@(posedge pclk);
				wake <= 1'b0;
			end else begin
				apb(1'b1, HOST_CTRL_OFS, 32'h0);
			end
			wait_pin(1, 1'b0);
			chk("wake", 32'h1, {31'h0, ~doze & (n < 10)});
			apb(1'b1, HOST_CTRL_OFS, 32'h0);
		end
		spm <= 8'h10;
		apb(1'b1, HOST_CTRL_OFS, 32'h9);
		wait_pin(0, 1'b0);
		n0 = rise_cnt;
		repeat (3 * SMP) @(negedge pclk);
		chk("tx clock", 32'd3, 32'(rise_cnt - n0));
		// New level written in the low phase waits for the next clock rise
		wait (lnk_if.dcd_n === 1'b1);
		wait (lnk_if.dcd_n === 1'b0);
		apb(1'b1, HOST_CTRL_OFS, 32'hd);
		repeat (4) @(negedge pclk);
		chk("txd held", 32'h0, 32'(lnk_if.txd));
		wait (lnk_if.dcd_n === 1'b1);
		repeat (8) @(negedge pclk);
		chk("txd on rise", 32'h1, 32'(lnk_if.txd));
		apb(1'b1, HOST_CTRL_OFS, 32'h0);
		wait_pin(0, 1'b1);
		rxv <= 1'b1;
		rx_pulse(1'b0);
		repeat (2) @(negedge pclk);
		chk("rx clock high", 32'h2, {30'h0, lnk_if.dcd_n, lnk_if.rxd});
		repeat (RXCLK_HI_CYC + 4) @(negedge pclk);
		chk("rx clock low", 32'h0, {30'h0, lnk_if.dcd_n, lnk_if.rxd});
		end_sim();
	end
endmodule : test_direct_mode_serial_port
